//--- rtl/see_params.svh
// shared constants for the serial eeprom device and its controller
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH
// ==========================================
// timing
`define SEE_CLK_MHZ    20
`define SEE_WR_TIME_US 5000
`define SEE_SCL_QTR    5
// ==========================================
// slave address and address bytes
`define SEE_HDR_NORM   4'ha
`define SEE_HDR_SPEC   4'hb
`define SEE_DSEL_HI    3
`define SEE_DSEL_LO    1
`define SEE_RW_BIT     0
`define SEE_SEL_HI     2
`define SEE_SEL_LO     1
`define SEE_HI_BITS    5
`define SEE_PAGE_W     5
`define SEE_BITS       4'h8
`define SEE_IDX_HDR    2'h0
`define SEE_IDX_HI     2'h1
`define SEE_IDX_LO     2'h2
`define SEE_IDX_DATA   2'h3
// ==========================================
// storage images
`define SEE_ERASED     8'hff
`define SEE_LOCK_KEY   8'hff
`define SEE_LOCK_BIT   1
`define SEE_CFG_RST    8'h1d
`define SEE_CFG_WP     1
`define SEE_CFG_A_HI   7
`define SEE_CFG_A_LO   5
// ==========================================
// controller registers
`define SEE_REG_CMD    8'h00
`define SEE_REG_STAT   8'h04
`define SEE_CMD_START  8
`define SEE_CMD_STOP   9
`define SEE_CMD_READ   10
`define SEE_CMD_NACK   11
`define SEE_CMD_BYTE   12
`define SEE_CMD_WAIT   13
`define SEE_ST_BUSY    0
`define SEE_ST_ACK     1
`define SEE_ST_RX_LO   8
`define SEE_RESP_OKAY  2'b00
`define SEE_RESP_ERR   2'b10
`endif

//--- rtl/see_pkg.sv
// types shared by the serial eeprom device and its controller
package see_pkg;
  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_RX    = 3'b001,
    D_ACK   = 3'b010,
    D_TX    = 3'b011,
    D_TXACK = 3'b100
  } see_dev_st_t;
  typedef enum logic [1:0] {
    TGT_SEC  = 2'b00,
    TGT_FID  = 2'b01,
    TGT_LOCK = 2'b10,
    TGT_CFG  = 2'b11
  } see_tgt_t;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_BIT   = 3'b010,
    H_STOP  = 3'b011,
    H_WAIT  = 3'b100
  } see_host_st_t;
endpackage : see_pkg

//--- rtl/see_if.sv
// two-wire link between controller and eeprom device
`timescale 1ns/100ps
interface see_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // wired-and of both open-drain drivers with pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : see_if

//--- rtl/see_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module see_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // idle bus level is high, so both stages reset high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : see_sync

//--- rtl/see_device.sv
// serial eeprom device end: two-wire slave with special-access decoding
// What this block does
// RL1: config write via special header, selector x11x
// RL2: respond only when address-select bits match
// RL3: write protect refuses array, page, config writes
// RL4: protected config write may only clear protect
// RL5: master must not poll after config write
// RL6: master waits full write time after config
// RL7: read header: ack, shift current byte out
// RL8: nack then stop ends read, go idle
// RL9: dummy write address loads the read counter
// RL10: sequential read wraps at end of memory
// RL11: secure page selector x00x, low bits position
// RL12: secure page read wraps to zero
// RL13: config read shows don't-care bits as ones
// RL14: config read repeats same byte while acked
// RL15: identifier read selector x01x, nibble 0000
// RL16: sixteen identifier bytes, then restart
// RL17: locked secure page write is not acked
// RL18: master sends start then stop after probe
// RL19: lock status read, bit one shows lock
// RL20: delivered state erased array, config 1dh
// RL21: data byte acked only when writable
// RL22: identifier region never altered by writes
// RL23: address bits ten, nine choose special target
`timescale 1ns/100ps
`include "see_params.svh"
module see_device import see_pkg::*; #(
  parameter int             ADDR_W    = 13,
  parameter int             SEC_W     = 6,
  parameter int             WR_CYCLES = `SEE_WR_TIME_US * `SEE_CLK_MHZ,
  // arbitrary identifier value
  parameter logic [127:0]   FID_VALUE = 128'h0123456789abcdeffedcba9876543210
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  see_if.dev        bus,
  output logic      wp_active,
  output logic      page_locked,
  output logic      write_busy
);
  localparam int BW = $clog2(WR_CYCLES + 1);
  if (ADDR_W < 9 || ADDR_W > 13 || SEC_W < 1 || SEC_W > 6 || WR_CYCLES < 1) begin : g_chk
    $error("see_device: unsupported parameters");
  end
  // ==========================================
  // link sampling
  logic scl_s, sda_s, scl_q, sda_q;
  see_sync #(.W(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({bus.scl, bus.sda}),
    .q       ({scl_s, sda_s})
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  // ==========================================
  // state
  see_dev_st_t       st;
  see_tgt_t          sel;
  logic [7:0]        sh;
  logic [3:0]        bitcnt;
  logic [1:0]        byte_idx;
  logic              drv_low, go_tx, more, hdr_spec;
  logic [ADDR_W-1:0] addr;
  logic [SEC_W-1:0]  sptr;
  logic [3:0]        uptr;
  logic [2:0]        cfg_a;
  logic              soft_write_protect_bit, locked, wr_pend;
  logic [BW-1:0]     busy_cnt;
  logic [7:0]        mem   [0:(1<<ADDR_W)-1];
  logic [7:0]        sec   [0:(1<<SEC_W)-1];
  logic [(1<<ADDR_W)-1:0] prog;
  logic [(1<<SEC_W)-1:0]  sprog;
  // ==========================================
  // decode
  logic [7:0] rd_byte;
  logic       sp_ok, wr_ok, ack_now, ev_acc, ev_data, ev_load;
  always_comb begin
    rd_byte = `SEE_ERASED;
    if (!hdr_spec) begin
      if (prog[addr]) rd_byte = mem[addr];  // [RL20]
    end else begin
      case (sel)
        TGT_SEC:  if (sprog[sptr]) rd_byte = sec[sptr];
        TGT_FID:  rd_byte = FID_VALUE[{uptr, 3'h0} +: 8];
        TGT_LOCK: begin
          rd_byte = 8'h00;
          rd_byte[`SEE_LOCK_BIT] = locked;  // [RL19]
        end
        default: begin
          rd_byte = `SEE_CFG_RST;  // [RL13]
          rd_byte[`SEE_CFG_A_HI:`SEE_CFG_A_LO] = cfg_a;
          rd_byte[`SEE_CFG_WP] = soft_write_protect_bit;
        end
      endcase
    end
  end
  always_comb begin
    case (sel)
      TGT_SEC:  sp_ok = !soft_write_protect_bit && !locked;  // [RL3]
      TGT_FID:  sp_ok = 1'b0;  // [RL22]
      TGT_LOCK: sp_ok = !soft_write_protect_bit && (sh == `SEE_LOCK_KEY);
      default:  sp_ok = !soft_write_protect_bit || !sh[`SEE_CFG_WP];  // [RL4]
    endcase
    wr_ok = hdr_spec ? sp_ok : !soft_write_protect_bit;  // [RL3]
    case (byte_idx)
      `SEE_IDX_HDR: ack_now = (sh[7:4] == `SEE_HDR_NORM || sh[7:4] == `SEE_HDR_SPEC)
                              && sh[`SEE_DSEL_HI:`SEE_DSEL_LO] == cfg_a && busy_cnt == '0;  // [RL2]
      `SEE_IDX_HI:  ack_now = 1'b1;
      `SEE_IDX_LO:  ack_now = !(hdr_spec && sel == TGT_SEC && (soft_write_protect_bit || locked));  // [RL17]
      default:      ack_now = wr_ok;  // [RL21]
    endcase
  end
  assign ev_acc  = scl_fall && st == D_RX && bitcnt == `SEE_BITS && ack_now;
  assign ev_data = ev_acc && byte_idx == `SEE_IDX_DATA;
  assign ev_load = scl_fall && ((st == D_ACK && go_tx) || (st == D_TXACK && more));
  // ==========================================
  // bit and byte engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st       <= D_IDLE;
      sh       <= 8'h00;
      bitcnt   <= 4'h0;
      byte_idx <= `SEE_IDX_HDR;
      drv_low  <= 1'b0;
      go_tx    <= 1'b0;
      more     <= 1'b0;
      hdr_spec <= 1'b0;
    end else if (start_c) begin
      st       <= D_RX;
      bitcnt   <= 4'h0;
      byte_idx <= `SEE_IDX_HDR;
      drv_low  <= 1'b0;
      go_tx    <= 1'b0;
    end else if (stop_c) begin
      st      <= D_IDLE;  // [RL8]
      drv_low <= 1'b0;
    end else if (ev_load) begin
      st      <= D_TX;  // [RL7]
      sh      <= {rd_byte[6:0], 1'b0};
      drv_low <= !rd_byte[7];
      bitcnt  <= 4'h1;
    end else begin
      case (st)
        D_RX: begin
          if (scl_rise) begin
            sh     <= {sh[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `SEE_BITS) begin
            st      <= ack_now ? D_ACK : D_IDLE;
            drv_low <= ack_now;
            if (byte_idx == `SEE_IDX_HDR) begin
              go_tx    <= sh[`SEE_RW_BIT];
              hdr_spec <= sh[7:4] == `SEE_HDR_SPEC;
            end
            if (byte_idx != `SEE_IDX_DATA) byte_idx <= byte_idx + 2'h1;
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            st      <= D_RX;
            bitcnt  <= 4'h0;
            drv_low <= 1'b0;
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bitcnt == `SEE_BITS) begin
              st      <= D_TXACK;
              drv_low <= 1'b0;
            end else begin
              drv_low <= !sh[7];
              sh      <= {sh[6:0], 1'b0};
              bitcnt  <= bitcnt + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) more <= !sda_s;
          else if (scl_fall) st <= D_IDLE;  // [RL8]
        end
        default: st <= D_IDLE;
      endcase
    end
  end
  // ==========================================
  // pointers, configuration and lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr   <= '0;
      sel    <= TGT_SEC;
      sptr   <= '0;
      uptr   <= 4'h0;
      cfg_a  <= 3'h0;  // [RL20]
      soft_write_protect_bit <= 1'b0;
      locked <= 1'b0;
      prog   <= '0;
      sprog  <= '0;
    end else if (ev_acc) begin
      case (byte_idx)
        `SEE_IDX_HI: begin
          if (hdr_spec) sel <= see_tgt_t'(sh[`SEE_SEL_HI:`SEE_SEL_LO]);  // [RL23]
          else addr <= ADDR_W'({sh[`SEE_HI_BITS-1:0], addr[7:0]});  // [RL9]
        end
        `SEE_IDX_LO: begin
          if (hdr_spec) begin
            sptr <= sh[SEC_W-1:0];  // [RL11]
            uptr <= 4'h0;  // [RL15]
          end else addr <= {addr[ADDR_W-1:8], sh};  // [RL9]
        end
        `SEE_IDX_DATA: begin
          if (!hdr_spec) begin
            prog[addr] <= 1'b1;
            addr <= {addr[ADDR_W-1:`SEE_PAGE_W], addr[`SEE_PAGE_W-1:0] + `SEE_PAGE_W'(1)};
          end else begin
            case (sel)
              TGT_SEC: begin
                sprog[sptr] <= 1'b1;
                sptr <= sptr + SEC_W'(1);
              end
              TGT_LOCK: locked <= 1'b1;
              TGT_CFG: begin
                if (soft_write_protect_bit) soft_write_protect_bit <= 1'b0;  // [RL4]
                else begin
                  cfg_a                  <= sh[`SEE_CFG_A_HI:`SEE_CFG_A_LO];  // [RL1]
                  soft_write_protect_bit <= sh[`SEE_CFG_WP];
                end
              end
              default: uptr <= uptr;  // [RL22]
            endcase
          end
        end
        default: addr <= addr;
      endcase
    end else if (ev_load) begin
      if (!hdr_spec) addr <= addr + ADDR_W'(1);  // [RL10]
      else if (sel == TGT_SEC) sptr <= sptr + SEC_W'(1);  // [RL12]
      else if (sel == TGT_FID) uptr <= uptr + 4'h1;  // [RL16]
      // config and lock reads repeat the same byte [RL14]
    end
  end
  // arrays hold no reset; the programmed bits stand in for erase
  always_ff @(posedge aclk) begin
    if (ev_data && !hdr_spec) mem[addr] <= sh;
    if (ev_data && hdr_spec && sel == TGT_SEC) sec[sptr] <= sh;
  end
  // ==========================================
  // internal write time after stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_pend  <= 1'b0;
      busy_cnt <= '0;
    end else begin
      if (busy_cnt != '0) busy_cnt <= busy_cnt - BW'(1);
      if (ev_data) wr_pend <= 1'b1;
      else if (stop_c && wr_pend) begin
        wr_pend  <= 1'b0;
        busy_cnt <= BW'(WR_CYCLES);  // [RL5]
      end
    end
  end
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = !drv_low;
  assign wp_active        = soft_write_protect_bit;
  assign page_locked      = locked;
  assign write_busy       = busy_cnt != '0;
endmodule : see_device

//--- rtl/see_host.sv
// controller end: axi4-lite command registers driving the two-wire link
`timescale 1ns/100ps
`include "see_params.svh"
module see_host import see_pkg::*; #(
  parameter int QTR       = `SEE_SCL_QTR,
  parameter int WR_CYCLES = `SEE_WR_TIME_US * `SEE_CLK_MHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  see_if.host              bus
);
  localparam int QW = $clog2(QTR + 1);
  localparam int WW = $clog2(WR_CYCLES + 1);
  if (QTR < 4 || WR_CYCLES < 1) begin : g_chk
    $error("see_host: unsupported parameters");
  end
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask
  // ==========================================
  // register slave
  see_host_st_t hst;
  logic         aw_got, w_got, do_wr, cmd_go, busy;
  logic [7:0]   aw_q;
  logic [31:0]  w_q, cmd;
  logic [3:0]   strb_q;
  logic [7:0]   rx;
  logic         ack_rx;
  assign busy          = hst != H_IDLE;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_got && w_got && !s_axi_bvalid;
  assign cmd           = w_q & lane_mask(strb_q);
  assign cmd_go        = do_wr && aw_q == `SEE_REG_CMD && !busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_q         <= 8'h00;
      w_q          <= 32'h0000_0000;
      strb_q       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SEE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_q    <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= cmd_go ? `SEE_RESP_OKAY : `SEE_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SEE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SEE_RESP_OKAY;
      if (s_axi_araddr == `SEE_REG_STAT) begin
        s_axi_rdata[`SEE_ST_BUSY] <= busy;
        s_axi_rdata[`SEE_ST_ACK]  <= ack_rx;
        s_axi_rdata[`SEE_ST_RX_LO +: 8] <= rx;
      end else if (s_axi_araddr != `SEE_REG_CMD) s_axi_rresp <= `SEE_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  // ==========================================
  // link engine: four quarters per bit, no clock stretching
  logic          sda_s, scl_o, drv_low;
  logic [1:0]    ph;
  logic [QW-1:0] qcnt;
  logic [WW-1:0] wcnt;
  logic [3:0]    bitn;
  logic [7:0]    tx;
  logic          c_start, c_stop, c_read, c_nack, c_byte, c_wait;
  see_sync #(.W(1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (bus.sda),
    .q       (sda_s)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hst     <= H_IDLE;
      ph      <= 2'h0;
      qcnt    <= '0;
      wcnt    <= '0;
      bitn    <= 4'h0;
      tx      <= 8'h00;
      rx      <= 8'h00;
      ack_rx  <= 1'b0;
      scl_o   <= 1'b1;
      drv_low <= 1'b0;
      {c_start, c_stop, c_read, c_nack, c_byte, c_wait} <= 6'h00;
    end else if (hst == H_IDLE) begin
      qcnt <= '0;
      ph   <= 2'h0;
      if (cmd_go) begin
        tx      <= cmd[7:0];
        bitn    <= 4'h0;
        c_start <= cmd[`SEE_CMD_START];
        c_stop  <= cmd[`SEE_CMD_STOP];
        c_read  <= cmd[`SEE_CMD_READ];
        c_nack  <= cmd[`SEE_CMD_NACK];
        c_byte  <= cmd[`SEE_CMD_BYTE];
        c_wait  <= cmd[`SEE_CMD_WAIT];
        if (cmd[`SEE_CMD_START]) hst <= H_START;  // [RL18]
        else if (cmd[`SEE_CMD_BYTE]) hst <= H_BIT;
        else if (cmd[`SEE_CMD_STOP]) hst <= H_STOP;
      end
    end else if (hst == H_WAIT) begin
      // fixed wait instead of polling the device [RL5] [RL6]
      if (wcnt == '0) hst <= H_IDLE;
      else wcnt <= wcnt - WW'(1);
    end else if (qcnt != QW'(QTR - 1)) qcnt <= qcnt + QW'(1);
    else begin
      qcnt <= '0;
      ph   <= ph + 2'h1;
      case (hst)
        H_START: begin
          case (ph)
            2'h0: drv_low <= 1'b0;
            2'h1: scl_o <= 1'b1;
            2'h2: drv_low <= 1'b1;
            default: begin
              scl_o <= 1'b0;
              hst <= c_byte ? H_BIT : (c_stop ? H_STOP : H_IDLE);
            end
          endcase
        end
        H_BIT: begin
          case (ph)
            2'h0: drv_low <= bitn[3] ? (c_read && !c_nack) : (!c_read && !tx[7]);
            2'h1: scl_o <= 1'b1;
            2'h2: begin
              if (bitn[3]) ack_rx <= !sda_s;
              else rx <= {rx[6:0], sda_s};
            end
            default: begin
              scl_o <= 1'b0;
              tx    <= {tx[6:0], 1'b0};
              bitn  <= bitn + 4'h1;
              if (bitn[3]) hst <= c_stop ? H_STOP : H_IDLE;
            end
          endcase
        end
        H_STOP: begin
          case (ph)
            2'h0: drv_low <= 1'b1;
            2'h1: scl_o <= 1'b1;
            2'h2: drv_low <= 1'b0;
            default: begin
              wcnt <= WW'(WR_CYCLES);
              hst  <= c_wait ? H_WAIT : H_IDLE;
            end
          endcase
        end
        default: hst <= H_IDLE;
      endcase
    end
  end
  assign bus.scl           = scl_o;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = !drv_low;
endmodule : see_host

//--- test/see_props.sv
// link assertions for the controller and device pair
`timescale 1ns/100ps
module see_props #(
  parameter int WR_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda,
  input wire logic wp_active,
  input wire logic page_locked,
  input wire logic write_busy
);
  // ==========
  // helper logic
  int busy_len;
  // a counter, since the busy span is far beyond a repetition count
  always_ff @(posedge aclk) begin
    if (!aresetn || !write_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // assertions
  a_dev_open_drain: assert property (dev_sda_o == 1'b0) else $error("device drives sda high");
  a_host_open_drain: assert property (host_sda_o == 1'b0) else $error("host drives sda high");
  a_dev_turn_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed sda while scl high");
  a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> !host_sda_oe_n)
    else $error("sda fall with scl high not from host");
  a_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> $past(dev_sda_oe_n))
    else $error("device held sda at stop");
  a_busy_silent: assert property (write_busy |-> dev_sda_oe_n) else $error("device acked while busy");
  a_busy_length: assert property ($fell(write_busy) |-> busy_len >= WR_CYCLES - 1 && busy_len <= WR_CYCLES + 1)
    else $error("write time length wrong");
  a_busy_idle_bus: assert property ($rose(write_busy) |-> scl && sda)
    else $error("write time began outside stop");
  a_lock_sticky: assert property ($past(page_locked) |-> page_locked) else $error("lock bit cleared");
  c_write: cover property ($rose(write_busy));
  c_lock: cover property ($rose(page_locked));
  c_unprotect: cover property ($fell(wp_active));
  c_dev_drive: cover property ($fell(dev_sda_oe_n));
endmodule : see_props

//--- test/test_serial_eeprom_special_access.sv
// testbench: axi controller and eeprom device joined on the two-wire link
`timescale 1ns/100ps
`include "see_params.svh"
module test_serial_eeprom_special_access;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wp_active, page_locked, write_busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          err_total, n_compared;
  localparam logic [31:0] ST = 32'h1 << `SEE_CMD_START;
  localparam logic [31:0] SP = 32'h1 << `SEE_CMD_STOP;
  localparam logic [31:0] RD = 32'h1 << `SEE_CMD_READ;
  localparam logic [31:0] NK = 32'h1 << `SEE_CMD_NACK;
  localparam logic [31:0] BY = 32'h1 << `SEE_CMD_BYTE;
  localparam logic [31:0] WT = 32'h1 << `SEE_CMD_WAIT;
  // arbitrary identifier value
  localparam logic [127:0] FID = 128'h5a3c96e10f2b7d48c1e0a9b8765f4d23;
  see_if lnk ();
  // host waits twice the device write time, the device times from its own stop detection
  see_host #(.WR_CYCLES(40)) see_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .bus(lnk.host));
  see_device #(.WR_CYCLES(20), .FID_VALUE(FID)) see_device_inst (.aclk(aclk), .aresetn(aresetn),
    .bus(lnk.dev), .wp_active(wp_active), .page_locked(page_locked), .write_busy(write_busy));
  see_props #(.WR_CYCLES(20)) see_props_inst (.aclk(aclk), .aresetn(aresetn), .scl(lnk.scl),
    .host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n), .dev_sda_o(lnk.dev_sda_o),
    .dev_sda_oe_n(lnk.dev_sda_oe_n), .sda(lnk.sda), .wp_active(wp_active),
    .page_locked(page_locked), .write_busy(write_busy));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axr
  task automatic op(input logic [31:0] c, output logic [31:0] st);
    logic [1:0] r;
    axw(`SEE_REG_CMD, c, r);
    do axr(`SEE_REG_STAT, st, r); while (st[`SEE_ST_BUSY] !== 1'b0);
  endtask : op
  task automatic sb(input logic [31:0] c, input logic ea);
    logic [31:0] st;
    op(BY | c, st);
    chk(st[`SEE_ST_ACK], ea);
  endtask : sb
  task automatic rb(input logic [31:0] c, input logic [7:0] ex);
    logic [31:0] st;
    op(BY | RD | c, st);
    chk(st[15:8], ex);
  endtask : rb
  // dummy write of two address bytes, then restart with read
  task automatic pre(input logic [7:0] h, hi, lo);
    sb(ST | h, 1);
    sb(hi, 1);
    sb(lo, 1);
    sb(ST | h | 1, 1);
  endtask : pre
  task automatic wr(input logic [7:0] h, hi, lo, dv, input logic ea);
    sb(ST | h, 1);
    sb(hi, 1);
    sb(lo, 1);
    sb(SP | WT | dv, ea);
  endtask : wr
  // don't-care bits of the selector byte are random
  function automatic logic [7:0] sel(input logic [1:0] t);
    return {5'($urandom), t, 1'($urandom)};
  endfunction : sel
  // ==========
  // clock, watchdog, sequence
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    #5_000_000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [12:0] a;
    logic [7:0]  v, w;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(84861));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    pre(8'hb0, sel(2'b11), 8'($urandom));
    rb(0, 8'h1d);
    rb(NK | SP, 8'h1d);
    a = 13'h0100 + 13'($urandom % 7680);
    v = 8'($urandom);
    w = 8'($urandom);
    pre(8'ha0, {3'h0, a[12:8]}, a[7:0]);
    rb(NK | SP, 8'hff);
    wr(8'ha0, {3'h0, a[12:8]}, a[7:0], v, 1);
    pre(8'ha0, {3'h0, a[12:8]}, a[7:0]);
    rb(0, v);
    rb(NK | SP, 8'hff);
    sb(ST | 8'ha1, 1);
    rb(NK | SP, 8'hff);
    wr(8'ha0, 8'h00, 8'h00, w, 1);
    pre(8'ha0, 8'h1f, 8'hff);
    rb(0, 8'hff);
    rb(NK | SP, w);
    pre(8'hb0, sel(2'b01), {4'($urandom), 4'h0});
    for (int k = 0; k < 17; k++) rb(k == 16 ? NK | SP : 32'h0, FID[8*(k%16) +: 8]);
    wr(8'hb0, sel(2'b01), 8'h00, ~FID[7:0], 0);
    pre(8'hb0, sel(2'b01), 8'h00);
    rb(NK | SP, FID[7:0]);
    sb(ST | 8'hb0, 1);
    sb(sel(2'b00), 1);
    sb({2'($urandom), 6'h3f}, 1);
    sb(v, 1);
    sb(SP | WT | w, 1);
    pre(8'hb0, sel(2'b00), 8'h3f);
    rb(0, v);
    rb(NK | SP, w);
    pre(8'hb0, sel(2'b10), 8'($urandom));
    rb(NK | SP, 8'h00);
    wr(8'hb0, sel(2'b10), 8'($urandom), 8'hff, 1);
    chk(page_locked, 1);
    pre(8'hb0, sel(2'b10), 8'($urandom));
    rb(NK | SP, 8'h02);
    sb(ST | 8'hb0, 1);
    sb(sel(2'b00), 1);
    sb(8'h00, 0);
    op(ST | SP, d);
    wr(8'hb0, sel(2'b11), 8'($urandom), 8'h02, 1);
    chk(wp_active, 1);
    wr(8'ha0, {3'h0, a[12:8]}, a[7:0], ~v, 0);
    pre(8'ha0, {3'h0, a[12:8]}, a[7:0]);
    rb(NK | SP, v);
    wr(8'hb0, sel(2'b11), 8'($urandom), 8'he2, 0);
    wr(8'hb0, sel(2'b11), 8'($urandom), 8'he0, 1);
    pre(8'hb0, sel(2'b11), 8'($urandom));
    rb(NK | SP, 8'h1d);
    wr(8'hb0, sel(2'b11), 8'($urandom), 8'h60, 1);
    sb(ST | SP | 8'ha0, 0);
    pre(8'hb6, sel(2'b11), 8'($urandom));
    rb(NK | SP, 8'h7d);
    axr(8'h08, d, r);
    chk(r, `SEE_RESP_ERR);
    axw(`SEE_REG_STAT, 32'h0, r);
    chk(r, `SEE_RESP_ERR);
    tally_and_finish;
  end
endmodule : test_serial_eeprom_special_access
